// ---- hw/crma_agent.sv ----
// Configuration message agent: decodes requests and sends replies.
`timescale 1ns/1ps
module crma_agent #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk, // System clock, 200 MHz.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic [7:0] rx_data, // Incoming byte or token.
    input wire logic rx_ctrl, // Incoming item is a control token.
    input wire logic rx_valid, // Incoming item offered.
    output logic rx_ready, // Agent takes the item.
    output logic [7:0] tx_data, // Outgoing byte or token.
    output logic tx_ctrl, // Outgoing item is a control token.
    output logic tx_valid, // Outgoing item offered.
    input wire logic tx_ready, // Link takes the item.
    output logic [23:0] tx_dest, // Reply channel-end, upper 24 bits.
    output logic [7:0] acc_space // Last access: 01 config, 02 periph.
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HDR = 6'b000010,
        ST_DATA = 6'b000100,
        ST_END = 6'b001000,
        ST_REPLY = 6'b010000,
        ST_DRAIN = 6'b100000
    } crma_state_t;

    localparam int NCREG = 1 << crma_pkg::CREG_BITS;
    localparam int NPREG = 1 << crma_pkg::PREG_BITS;

    crma_state_t st_r;
    logic [7:0] kind_r;
    logic [3:0] cnt_r;
    logic [23:0] id_r;
    logic [15:0] reg_r;
    logic [7:0] size_r;
    logic [31:0] wdat_r;
    logic bad_r;
    logic [7:0] psize_r;
    logic [3:0] rcnt_r;
    logic [31:0] creg_r [NCREG];
    logic [7:0] preg_r [NPREG];
    logic [7:0] acc_r;
    logic [8:0] q_data;
    logic q_valid;
    logic q_ready;
    logic [8:0] o_data;
    logic o_valid;
    logic rx_ready_r;
    logic [7:0] tx_data_r;
    logic tx_ctrl_r;
    logic tx_valid_r;
    logic is_cfg;
    logic is_wr;
    logic quiet;
    logic cfg_hit;
    logic p_hit;
    logic take;
    logic [3:0] hdr_len;
    logic [31:0] rval;

    // ****************************************************************
    // Request decode.
    // ****************************************************************

    // Derived request properties.
    assign is_cfg = kind_r == crma_pkg::TOK_CWR || kind_r == crma_pkg::TOK_CRD;
    assign is_wr = kind_r == crma_pkg::TOK_CWR || kind_r == crma_pkg::TOK_PWR;
    assign quiet = is_wr && id_r[7:0] == crma_pkg::NOREPLY_LOW;
    assign cfg_hit = reg_r < 16'(NCREG);
    assign p_hit = 9'(reg_r[7:0]) + 9'(size_r) <= 9'(NPREG);
    assign hdr_len = crma_pkg::ID_BYTES + (is_cfg ? crma_pkg::CREG_BYTES
                                                : crma_pkg::PHDR_BYTES);
    assign rx_ready = rx_ready_r;
    assign take = rx_valid && rx_ready_r;
    assign rval = creg_r[reg_r[crma_pkg::CREG_BITS-1:0]];

    // Intake closes as a message ends and opens once every reply item
    // has left, so tx_dest never shows the next requester too early.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_ready_r <= 1'b0;
        end else if (take && rx_ctrl && st_r != ST_IDLE) begin
            rx_ready_r <= 1'b0;
        end else if (st_r == ST_IDLE && !o_valid && !tx_valid_r) begin
            rx_ready_r <= 1'b1;
        end
    end

    // Message sequencer and field capture.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            kind_r <= 8'h00;
            cnt_r <= 4'h0;
            id_r <= 24'h00_0000;
            reg_r <= 16'h0000;
            size_r <= 8'h00;
            wdat_r <= 32'h0000_0000;
            bad_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (take) begin
                        kind_r <= rx_data;
                        cnt_r <= 4'h0;
                        reg_r <= 16'h0000;
                        bad_r <= 1'b0;
                        id_r <= 24'h00_0000;
                        // Unknown token drains to its end; bytes drop.
                        if (rx_ctrl && (rx_data == crma_pkg::TOK_CWR
                                || rx_data == crma_pkg::TOK_CRD
                                || rx_data == crma_pkg::TOK_PWR
                                || rx_data == crma_pkg::TOK_PRD)) begin
                            st_r <= ST_HDR;
                        end else if (rx_ctrl
                                && rx_data != crma_pkg::TOK_END) begin
                            st_r <= ST_DRAIN;
                        end
                    end
                end
                ST_HDR: begin
                    if (take) begin
                        if (rx_ctrl) begin
                            bad_r <= 1'b1;
                            st_r <= ST_REPLY;
                        end else begin
                            // Identifier then register, MSB first.
                            if (cnt_r < crma_pkg::ID_BYTES) begin
                                id_r <= {id_r[15:0], rx_data};
                            end else if (is_cfg) begin
                                reg_r <= {reg_r[7:0], rx_data};
                            end else if (cnt_r == crma_pkg::ID_BYTES) begin
                                reg_r <= {8'h00, rx_data};
                            end else begin
                                size_r <= rx_data;
                            end
                            cnt_r <= cnt_r + 4'h1;
                            if (cnt_r + 4'h1 == hdr_len) begin
                                cnt_r <= 4'h0;
                                st_r <= is_wr ? ST_DATA : ST_END;
                            end
                        end
                    end
                end
                ST_DATA: begin
                    if (take) begin
                        if (rx_ctrl) begin
                            // Short write: config writes need 4 bytes.
                            if (is_cfg || rx_data != crma_pkg::TOK_END
                                    || 8'(cnt_r) != size_r) begin
                                bad_r <= 1'b1;
                            end
                            st_r <= ST_REPLY;
                        end else begin
                            wdat_r <= {wdat_r[23:0], rx_data};
                            cnt_r <= cnt_r + 4'h1;
                            if (is_cfg && cnt_r == crma_pkg::CDATA_BYTES
                                    - 4'h1) begin
                                st_r <= ST_END;
                            end
                        end
                    end
                end
                ST_END: begin
                    if (take) begin
                        if (!(rx_ctrl && rx_data == crma_pkg::TOK_END)) begin
                            bad_r <= 1'b1;
                        end
                        st_r <= (rx_ctrl) ? ST_REPLY : ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (take && rx_ctrl) begin
                        bad_r <= 1'b1;
                        st_r <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    if (quiet) begin
                        st_r <= ST_IDLE;
                    end else if (q_ready && rcnt_r == psize_r[3:0]
                            + 4'h1) begin
                        st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Register banks and reply generation.
    // ****************************************************************

    // Register writes take effect when a well formed write closes.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < NCREG; i++) begin
                creg_r[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < NPREG; i++) begin
                preg_r[i] <= 8'h00;
            end
        end else if (st_r == ST_REPLY && rcnt_r == 4'h0 && !bad_r
                && is_wr) begin
            if (is_cfg && cfg_hit) begin
                creg_r[reg_r[crma_pkg::CREG_BITS-1:0]] <= wdat_r;
            end else if (!is_cfg && p_hit && size_r != 8'h00) begin
                preg_r[reg_r[crma_pkg::PREG_BITS-1:0]] <= wdat_r[7:0];
            end
        end
    end

    // Reply word: ACK or NACK, read data bytes, then end token.
    always_comb begin
        psize_r = 8'h00;
        if (!bad_r && !is_wr) begin
            psize_r = is_cfg ? 8'h04 : size_r;
        end
        if (bad_r || (is_cfg ? !cfg_hit : !p_hit)) begin
            psize_r = 8'h00;
        end
        q_data = {1'b1, crma_pkg::TOK_END};
        if (rcnt_r == 4'h0) begin
            q_data = {1'b1, (bad_r || (is_cfg ? !cfg_hit : !p_hit))
                      ? crma_pkg::TOK_NACK : crma_pkg::TOK_ACK};
        end else if (rcnt_r <= psize_r[3:0]) begin
            if (is_cfg) begin
                q_data = {1'b0, 8'(rval >> (8 * (4 - int'(rcnt_r))))};
            end else begin
                q_data = {1'b0, preg_r[reg_r[crma_pkg::PREG_BITS-1:0]
                          + (crma_pkg::PREG_BITS)'(rcnt_r - 4'h1)]};
            end
        end
        q_valid = st_r == ST_REPLY && !quiet;
    end

    // Reply item counter.
    always_ff @(posedge clk) begin
        if (!nrst || st_r != ST_REPLY) begin
            rcnt_r <= 4'h0;
        end else if (q_valid && q_ready) begin
            rcnt_r <= rcnt_r + 4'h1;
        end
    end

    // Access space, held per request and set as its reply starts.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_r <= 8'h00;
        end else if (st_r == ST_REPLY && rcnt_r == 4'h0) begin
            acc_r <= is_cfg ? crma_pkg::ACC_TILE : crma_pkg::ACC_PERIPH;
        end
    end

    crma_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_data(q_data),
        .in_valid(q_valid),
        .in_ready(q_ready),
        .out_data(o_data),
        .out_valid(o_valid),
        .out_ready(!tx_valid_r || tx_ready)
    );

    // Output stage: every output from a flip-flop.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_ctrl_r <= 1'b0;
            tx_dest <= 24'h00_0000;
        end else if (!tx_valid_r || tx_ready) begin
            tx_valid_r <= o_valid;
            tx_data_r <= o_data[7:0];
            tx_ctrl_r <= o_data[8];
            tx_dest <= id_r;
        end
    end

    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;
    assign tx_ctrl = tx_ctrl_r;
    assign acc_space = acc_r;

    // Suppressed writes never put an item in the reply queue.
    chk_quiet_noreply: assert property (@(posedge clk) disable iff (!nrst)
        st_r == ST_REPLY && quiet |-> !q_valid)
        else $error("Suppressed write queued a reply.");

    // Every reply opens with an ACK or NACK token.
    chk_reply_head: assert property (@(posedge clk) disable iff (!nrst)
        q_valid && rcnt_r == 4'h0 |-> q_data[8]
        && (q_data[7:0] == crma_pkg::TOK_ACK
            || q_data[7:0] == crma_pkg::TOK_NACK))
        else $error("Reply did not start with a status token.");

    // A failed request is answered with NACK.
    chk_fail_nack: assert property (@(posedge clk) disable iff (!nrst)
        q_valid && rcnt_r == 4'h0 && bad_r
        |-> q_data[7:0] == crma_pkg::TOK_NACK)
        else $error("Failed request was acknowledged.");

    // Config reads return four data bytes after ACK.
    chk_cfg_rlen: assert property (@(posedge clk) disable iff (!nrst)
        st_r == ST_REPLY && is_cfg && !is_wr && !bad_r && cfg_hit
        |-> psize_r == 8'h04)
        else $error("Config read length is not four bytes.");

    // Peripheral reads of up to 14 bytes return the requested size.
    chk_p_rlen: assert property (@(posedge clk) disable iff (!nrst)
        st_r == ST_REPLY && !is_cfg && !is_wr && !bad_r && p_hit
        |-> psize_r == size_r)
        else $error("Peripheral read length is wrong.");

    // Config data bytes go out most significant first.
    chk_msb_first: assert property (@(posedge clk) disable iff (!nrst)
        q_valid && is_cfg && rcnt_r == 4'h1 && psize_r == 8'h04
        |-> q_data[7:0] == rval[31:24])
        else $error("Config data not sent MSB first.");

    // Reply closes with the end token.
    chk_reply_end: assert property (@(posedge clk) disable iff (!nrst)
        q_valid && rcnt_r == psize_r[3:0] + 4'h1
        |-> q_data == {1'b1, crma_pkg::TOK_END})
        else $error("Reply not closed by end token.");

    // A config write token leads into header capture.
    chk_cwr_start: assert property (@(posedge clk) disable iff (!nrst)
        st_r == ST_IDLE && take && rx_ctrl && rx_data == crma_pkg::TOK_CWR
        |=> st_r == ST_HDR)
        else $error("Config write not accepted.");

    // No request item is taken while a reply is being queued.
    chk_intake_closed: assert property (@(posedge clk) disable iff (!nrst)
        st_r == ST_REPLY |-> !rx_ready_r)
        else $error("Intake open during reply.");
endmodule

// ---- hw/crma_pkg.sv ----
// Package of constants for the configuration message access agent.
package crma_pkg;
    // ****************************************************************
    // Control tokens.
    // ****************************************************************
    localparam logic [7:0] TOK_END = 8'h01;
    localparam logic [7:0] TOK_ACK = 8'h03;
    localparam logic [7:0] TOK_NACK = 8'h04;
    localparam logic [7:0] TOK_PWR = 8'h24;
    localparam logic [7:0] TOK_PRD = 8'h25;
    localparam logic [7:0] TOK_CWR = 8'hC0;
    localparam logic [7:0] TOK_CRD = 8'hC1;
    // ****************************************************************
    // Field sizes in bytes and reply suppression pattern.
    // ****************************************************************
    localparam logic [7:0] NOREPLY_LOW = 8'hFF;
    localparam logic [3:0] ID_BYTES = 4'h3;
    localparam logic [3:0] CREG_BYTES = 4'h2;
    localparam logic [3:0] CDATA_BYTES = 4'h4;
    localparam logic [3:0] PHDR_BYTES = 4'h2;
    // ****************************************************************
    // Register banks: tile and node registers, peripheral bytes.
    // ****************************************************************
    localparam int CREG_BITS = 4;
    localparam int PREG_BITS = 4;
    localparam logic [7:0] ACC_TILE = 8'h01;
    localparam logic [7:0] ACC_PERIPH = 8'h02;
endpackage

// ---- hw/crma_fifo.sv ----
// Reply token FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module crma_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Word to store.
    input wire logic in_valid, // Word offered.
    output logic in_ready, // Room available.
    output logic [WIDTH-1:0] out_data, // Oldest word, read straight from storage.
    output logic out_valid, // Oldest word present.
    input wire logic out_ready // Drain accepts word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    // Handshake terms and honest full and empty.
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rp_r];

    // Storage writes.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- verification/crma_peer.sv ----
// Requester channel-end model that takes reply items, stalling on request.
`timescale 1ns/1ps
module crma_peer (
    input wire logic clk, // System clock.
    input wire logic nrst, // Synchronous reset, active low.
    input wire logic [7:0] tx_data, // Reply byte or token.
    input wire logic tx_ctrl, // Reply item is a token.
    input wire logic tx_valid, // Reply item offered.
    input wire logic slow, // Take only one item in three cycles.
    output logic tx_ready // Model takes the item.
);
    logic [1:0] phase_r;
    logic [8:0] got[$];

    // Ready always, or one cycle in three so that the reply queue fills.
    assign tx_ready = !slow || (phase_r == 2'h2);

    // Store each item taken, token flag above the byte.
    always @(posedge clk) begin
        if (!nrst) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            if (tx_valid && tx_ready) begin
                got.push_back({tx_ctrl, tx_data});
            end
        end
    end
endmodule

// ---- verification/crma_agent_tb_top.sv ----
// Self-checking bench for the configuration message agent.
`timescale 1ns/1ps
module crma_agent_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_ctrl = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_ready;
    logic [7:0] tx_data;
    logic tx_ctrl;
    logic tx_valid;
    logic tx_ready;
    logic [23:0] tx_dest;
    logic [7:0] acc_space;
    logic slow = 1'b0;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [8:0] exp_q[$];

    // Clock of 5 ns period.
    always #2.5 clk = ~clk;

    crma_agent #(.FIFO_DEPTH(4)) uut (
        .clk(clk), .nrst(nrst), .rx_data(rx_data), .rx_ctrl(rx_ctrl),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_ctrl(tx_ctrl), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_dest(tx_dest), .acc_space(acc_space)
    );

    crma_peer peer (
        .clk(clk), .nrst(nrst), .tx_data(tx_data), .tx_ctrl(tx_ctrl),
        .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready)
    );

    // ****************************************************************
    // Verdict, comparison and hang guard.
    // ****************************************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            fails++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Ends a run that has hung well past the expected length.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    // ****************************************************************
    // Request driving and reply collection.
    // ****************************************************************
    function automatic logic [8:0] tk(input logic [7:0] t);
        return {1'b1, t};
    endfunction

    function automatic logic [8:0] by(input logic [7:0] b);
        return {1'b0, b};
    endfunction

    // Destination words a requester sets for each bank.
    function automatic logic [31:0] dest_tile(input logic [15:0] t);
        return {t, 16'hC20C};
    endfunction

    function automatic logic [31:0] dest_node(input logic [15:0] n);
        return {n, 16'hC30C};
    endfunction

    function automatic logic [31:0] dest_periph(input logic [15:0] n,
                                                input logic [7:0] p);
        return {n, p, 8'h02};
    endfunction

    // Status resource number: register shifted up a byte, low byte 0B.
    function automatic logic [15:0] ps_res(input logic [7:0] r);
        return {r, 8'h0B};
    endfunction

    // Offers one item and holds it until the edge that takes it.
    task automatic put(input logic c, input logic [7:0] d);
        int n;
        n = 0;
        rx_ctrl <= c;
        rx_data <= d;
        rx_valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (!rx_ready && n < 200);
        @(posedge clk);
    endtask

    // Sends the low bytes of a value, most significant byte first.
    task automatic put_bytes(input logic [31:0] v, input int nb);
        for (int i = nb - 1; i >= 0; i--) begin
            put(1'b0, v[8*i +: 8]);
        end
    endtask

    // Tile or node request: token, id, 16-bit register, data on write.
    task automatic cfg(input logic [7:0] t, input logic [23:0] id,
                       input logic [15:0] rg, input logic [31:0] d);
        put(1'b1, t);
        put_bytes(id, 3);
        put_bytes(rg, 2);
        if (t == crma_pkg::TOK_CWR) put_bytes(d, 4);
        put(1'b1, crma_pkg::TOK_END);
        rx_valid <= 1'b0;
        @(negedge clk);
        check(rx_ready, 1'b0);
    endtask

    // Peripheral request: token, id, register, size, data on write.
    task automatic per(input logic [7:0] t, input logic [7:0] rg,
                       input logic [7:0] sz, input logic [31:0] d);
        put(1'b1, t);
        put_bytes(24'(dest_periph(16'h0044, 8'h00) >> 8), 3);
        put(1'b0, rg);
        put(1'b0, sz);
        if (t == crma_pkg::TOK_PWR) put_bytes(d, int'(sz));
        put(1'b1, crma_pkg::TOK_END);
        rx_valid <= 1'b0;
    endtask

    // Waits for the expected reply items, then checks for stray extras.
    task automatic expect_reply();
        int n;
        n = 0;
        while (peer.got.size() < exp_q.size() && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (12) @(negedge clk);
        check(peer.got.size(), exp_q.size());
        for (int i = 0; i < exp_q.size() && i < peer.got.size(); i++) begin
            check(peer.got[i], exp_q[i]);
        end
        peer.got.delete();
        exp_q.delete();
        @(posedge clk);
    endtask

    task automatic want_nack();
        exp_q = '{tk(crma_pkg::TOK_NACK), tk(crma_pkg::TOK_END)};
        expect_reply();
    endtask

    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    // Write then read back a word while the link stalls the reply.
    task automatic t_config();
        slow <= 1'b1;
        cfg(crma_pkg::TOK_CWR, 24'(dest_node(16'h1234) >> 8), 16'h0005,
            32'h1234_5678);
        exp_q = '{tk(crma_pkg::TOK_ACK), tk(crma_pkg::TOK_END)};
        expect_reply();
        check(tx_dest, 24'h12_34C3);
        check(acc_space, crma_pkg::ACC_TILE);
        cfg(crma_pkg::TOK_CRD, 24'(dest_tile(16'h6543) >> 8), 16'h0005,
            32'h0000_0000);
        exp_q = '{tk(crma_pkg::TOK_ACK), by(8'h12), by(8'h34), by(8'h56),
                  by(8'h78), tk(crma_pkg::TOK_END)};
        expect_reply();
        check(tx_dest, 24'h65_43C2);
        slow <= 1'b0;
        $display("test config done");
    endtask

    // A write to the top register with reply suppressed, then read back.
    task automatic t_noreply();
        cfg(crma_pkg::TOK_CWR, 24'h00_77FF, 16'h000F, 32'hCAFE_0001);
        expect_reply();
        cfg(crma_pkg::TOK_CRD, 24'h00_7701, 16'h000F, 32'h0000_0000);
        exp_q = '{tk(crma_pkg::TOK_ACK), by(8'hCA), by(8'hFE), by(8'h00),
                  by(8'h01), tk(crma_pkg::TOK_END)};
        expect_reply();
        $display("test noreply done");
    endtask

    // Failed requests must be refused and must not alter a register.
    task automatic t_bad();
        cfg(crma_pkg::TOK_CRD, 24'h01_0203, 16'h0010, 32'h0000_0000);
        want_nack();
        cfg(crma_pkg::TOK_CWR, 24'h01_0203, ps_res(8'h01),
            32'h0000_0000);
        want_nack();
        put(1'b1, 8'h55);
        put(1'b1, crma_pkg::TOK_END);
        rx_valid <= 1'b0;
        want_nack();
        put(1'b1, crma_pkg::TOK_CWR);
        put_bytes(24'h01_0203, 3);
        put_bytes(16'h0005, 2);
        put_bytes(16'hABCD, 2);
        put(1'b1, crma_pkg::TOK_END);
        rx_valid <= 1'b0;
        want_nack();
        cfg(crma_pkg::TOK_CRD, 24'h01_0203, 16'h0005, 32'h0000_0000);
        exp_q = '{tk(crma_pkg::TOK_ACK), by(8'h12), by(8'h34), by(8'h56),
                  by(8'h78), tk(crma_pkg::TOK_END)};
        expect_reply();
        $display("test bad done");
    endtask

    // Peripheral byte writes and sized reads, with a range overrun.
    task automatic t_periph();
        per(crma_pkg::TOK_PWR, 8'h02, 8'h01, 32'h0000_00AB);
        exp_q = '{tk(crma_pkg::TOK_ACK), tk(crma_pkg::TOK_END)};
        expect_reply();
        per(crma_pkg::TOK_PWR, 8'h04, 8'h02, 32'h0000_1122);
        exp_q = '{tk(crma_pkg::TOK_ACK), tk(crma_pkg::TOK_END)};
        expect_reply();
        per(crma_pkg::TOK_PRD, 8'h02, 8'h03, 32'h0000_0000);
        exp_q = '{tk(crma_pkg::TOK_ACK), by(8'hAB), by(8'h00), by(8'h22),
                  tk(crma_pkg::TOK_END)};
        expect_reply();
        check(acc_space, crma_pkg::ACC_PERIPH);
        per(crma_pkg::TOK_PRD, 8'h0D, 8'h03, 32'h0000_0000);
        exp_q = '{tk(crma_pkg::TOK_ACK), by(8'h00), by(8'h00), by(8'h00),
                  tk(crma_pkg::TOK_END)};
        expect_reply();
        per(crma_pkg::TOK_PRD, 8'h0E, 8'h03, 32'h0000_0000);
        want_nack();
        $display("test periph done");
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        check(tx_valid, 1'b0);
        check(tx_dest, 24'h00_0000);
        check(acc_space, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_config();
        t_noreply();
        t_bad();
        t_periph();
        close_out();
    end
endmodule
